// file: clk_edge_detect.sv
// edge detector for one sampled count clock
`timescale 1ns/1ps
`default_nettype none
`include "updown_counter_defs.svh"

module clk_edge_detect
    import counter_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic level_in,
    count_clock_if.detector clk_if
);

    edge_state_type state_ff;
    edge_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.level = level_in;
    end

    // previous level starts high, so a clock held high through reset
    // gives no rising edge when reset is released
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= '{level: `CLK_IDLE_LEVEL};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign clk_if.level = level_in;
    assign clk_if.rise = level_in & ~state_ff.level;
    assign clk_if.fall = ~level_in & state_ff.level;

endmodule

`default_nettype wire

// file: count_clock_if.sv
// one count clock as seen by the counter: level and its edges
`timescale 1ns/1ps
`default_nettype none

interface count_clock_if;
    logic level;
    logic rise;
    logic fall;

    modport detector (
        output level,
        output rise,
        output fall
    );

    modport user (
        input level,
        input rise,
        input fall
    );
endinterface

`default_nettype wire

// file: counter_chk.sv
// port assertions for the dual clock up/down counter
`timescale 1ns/1ps
`default_nettype none
`include "updown_counter_defs.svh"

module counter_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic up_count_clock_in,
    input wire logic down_count_clock_in,
    input wire logic preset_load_n_in,
    input wire logic master_clear_in,
    input wire logic [`CNT_WIDTH-1:0] preset_value_in,
    input wire logic [`CNT_WIDTH-1:0] count_value_out,
    input wire logic carry_out_n_out,
    input wire logic borrow_out_n_out
);
    logic up_ff;
    logic dn_ff;
    logic run;
    logic inc;
    logic dec;
    // history forced high in reset: a clock held high across it does not count on release
    always_ff @(posedge clk_in) begin
        up_ff <= rst_in | up_count_clock_in;
        dn_ff <= rst_in | down_count_clock_in;
    end
    assign run = preset_load_n_in & ~master_clear_in;
    assign inc = run & up_count_clock_in & ~up_ff & ~(down_count_clock_in & ~dn_ff)
        & down_count_clock_in;
    assign dec = run & down_count_clock_in & ~dn_ff & ~(up_count_clock_in & ~up_ff)
        & up_count_clock_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    count_up_a: assert property (
        inc |=> count_value_out == $past(count_value_out) + 4'h1)
        else $error("up step wrong");
    count_down_a: assert property (
        dec |=> count_value_out == $past(count_value_out) - 4'h1)
        else $error("down step wrong");
    count_hold_a: assert property (
        run && !inc && !dec |=> $stable(count_value_out))
        else $error("count moved without a step");
    clear_zero_a: assert property (
        master_clear_in |=> count_value_out == 4'h0)
        else $error("clear did not zero");
    preset_copy_a: assert property (
        !master_clear_in && !preset_load_n_in |=> count_value_out == $past(preset_value_in))
        else $error("preset not copied");
    carry_follow_a: assert property (
        1'h1 |=> carry_out_n_out == !(count_value_out == 4'hF && !$past(up_count_clock_in)))
        else $error("carry wrong");
    borrow_follow_a: assert property (
        1'h1 |=> borrow_out_n_out == !(count_value_out == 4'h0 && !$past(down_count_clock_in)))
        else $error("borrow wrong");
    carry_rest_a: assert property (
        count_value_out != 4'hF |-> carry_out_n_out)
        else $error("carry low off terminal");
    borrow_rest_a: assert property (
        count_value_out != 4'h0 |-> borrow_out_n_out)
        else $error("borrow low off terminal");
endmodule

bind dual_clock_updown_counter4 counter_chk u_chk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .up_count_clock_in(up_count_clock_in),
    .down_count_clock_in(down_count_clock_in),
    .preset_load_n_in(preset_load_n_in),
    .master_clear_in(master_clear_in),
    .preset_value_in(preset_value_in),
    .count_value_out(count_value_out),
    .carry_out_n_out(carry_out_n_out),
    .borrow_out_n_out(borrow_out_n_out)
);

`default_nettype wire

// file: counter_pkg.sv
// types shared by the dual clock up/down counter modules
`default_nettype none
`include "updown_counter_defs.svh"

package counter_pkg;

    typedef logic [`CNT_WIDTH-1:0] count_type;

    // operating mode, priority clear over load over count
    typedef enum logic [2:0] {
        MODE_CLEAR = 3'h1,
        MODE_LOAD  = 3'h2,
        MODE_COUNT = 3'h4
    } mode_type;

    // what the clock pair asks for in one cycle
    typedef enum logic [3:0] {
        STEP_HOLD    = 4'h1,
        STEP_UP      = 4'h2,
        STEP_DOWN    = 4'h4,
        STEP_BLOCKED = 4'h8
    } step_type;

    typedef struct packed {
        count_type count;
        mode_type mode;
        step_type last_step;
        logic carry_n;
        logic borrow_n;
    } counter_state_type;

    typedef struct packed {
        logic level;
    } edge_state_type;

endpackage

`default_nettype wire

// file: dual_clock_updown_counter4.sv
// 4-bit reversible counter with separate up and down count clocks
`timescale 1ns/1ps
`default_nettype none
`include "updown_counter_defs.svh"

module dual_clock_updown_counter4
    import counter_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic up_count_clock_in,
    input wire logic down_count_clock_in,
    input wire logic preset_load_n_in,
    input wire logic master_clear_in,
    input wire logic [`CNT_WIDTH-1:0] preset_value_in,
    output logic [`CNT_WIDTH-1:0] count_value_out,
    output logic carry_out_n_out,
    output logic borrow_out_n_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------

    counter_state_type state_ff;
    counter_state_type nxt_state;

    // ----------------------------------------------------------------
    // count clock edges
    // ----------------------------------------------------------------

    count_clock_if up_clk_if();
    count_clock_if down_clk_if();

    // edge history keeps running under clear and preset, so a clock
    // that was low there still yields its next rising edge
    clk_edge_detect up_edge_detect (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .level_in(up_count_clock_in),
        .clk_if(up_clk_if)
    );

    clk_edge_detect down_edge_detect (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .level_in(down_count_clock_in),
        .clk_if(down_clk_if)
    );

    // ----------------------------------------------------------------
    // mode selection
    // ----------------------------------------------------------------

    mode_type mode;

    always_comb begin
        if (master_clear_in) begin
            mode = MODE_CLEAR;
        end else if (!preset_load_n_in) begin
            mode = MODE_LOAD;
        end else begin
            mode = MODE_COUNT;
        end
    end

    // ----------------------------------------------------------------
    // step decision
    // ----------------------------------------------------------------

    step_type step;

    // a rising edge while the other clock is low does not step: the
    // first stage cannot toggle then, the driver must avoid it
    always_comb begin
        step = STEP_HOLD;
        if (up_clk_if.rise && down_clk_if.rise) begin
            step = STEP_BLOCKED;
        end else if (up_clk_if.rise) begin
            if (down_clk_if.level) begin
                step = STEP_UP;
            end else begin
                step = STEP_BLOCKED;
            end
        end else if (down_clk_if.rise) begin
            if (up_clk_if.level) begin
                step = STEP_DOWN;
            end else begin
                step = STEP_BLOCKED;
            end
        end
    end

    // ----------------------------------------------------------------
    // next count
    // ----------------------------------------------------------------

    count_type count_next;

    always_comb begin
        count_next = state_ff.count;
        case (mode)
            MODE_CLEAR: begin
                count_next = `CNT_RESET_VALUE;
            end
            MODE_LOAD: begin
                count_next = preset_value_in;
            end
            MODE_COUNT: begin
                case (step)
                    STEP_UP: begin
                        // 4-bit sum drops the carry, so 15 wraps to 0
                        count_next = count_type'(state_ff.count + `CNT_STEP);
                    end
                    STEP_DOWN: begin
                        // 4-bit difference, so 0 wraps to 15
                        count_next = count_type'(state_ff.count - `CNT_STEP);
                    end
                    STEP_HOLD: begin
                        count_next = state_ff.count;
                    end
                    STEP_BLOCKED: begin
                        count_next = state_ff.count;
                    end
                    default: begin
                        count_next = state_ff.count;
                    end
                endcase
            end
            default: begin
                count_next = `CNT_RESET_VALUE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // terminal count outputs
    // ----------------------------------------------------------------

    logic at_max;
    logic at_min;
    logic carry_n_next;
    logic borrow_n_next;

    // judged on the next count, so a preset to all ones or a clear
    // shows on the flags in the same cycle as on the count
    assign at_max = (count_next == `CNT_MAX_VALUE);
    assign at_min = (count_next == `CNT_MIN_VALUE);

    terminal_gate carry_gate (
        .at_terminal_in(at_max),
        .clk_if(up_clk_if),
        .flag_n_out(carry_n_next)
    );

    terminal_gate borrow_gate (
        .at_terminal_in(at_min),
        .clk_if(down_clk_if),
        .flag_n_out(borrow_n_next)
    );

    // ----------------------------------------------------------------
    // state update
    // ----------------------------------------------------------------

    always_comb begin
        nxt_state = state_ff;
        nxt_state.mode = mode;
        nxt_state.count = count_next;
        nxt_state.carry_n = carry_n_next;
        nxt_state.borrow_n = borrow_n_next;
        if (mode == MODE_COUNT && step != STEP_HOLD) begin
            nxt_state.last_step = step;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= '{
                count: `CNT_RESET_VALUE,
                mode: MODE_COUNT,
                last_step: STEP_HOLD,
                carry_n: `FLAG_IDLE_LEVEL,
                borrow_n: `FLAG_IDLE_LEVEL
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // all three come straight from the state register; a cascaded
    // stage sees carry and borrow aligned with this stage's count
    assign count_value_out = state_ff.count;
    assign carry_out_n_out = state_ff.carry_n;
    assign borrow_out_n_out = state_ff.borrow_n;

endmodule

`default_nettype wire

// file: next_stage_model.sv
// next cascaded stage clocked straight from carry and borrow
`timescale 1ns/1ps
`default_nettype none

module next_stage_model (
    input wire logic rst_in,
    input wire logic up_in,
    input wire logic down_in,
    output logic [3:0] count_out
);
    logic [3:0] ups_ff;
    logic [3:0] downs_ff;
    // two edge counters avoid one variable driven by two edge processes
    always @(posedge up_in or posedge rst_in) begin
        if (rst_in) begin
            ups_ff <= 4'h0;
        end else begin
            ups_ff <= ups_ff + 4'h1;
        end
    end
    always @(posedge down_in or posedge rst_in) begin
        if (rst_in) begin
            downs_ff <= 4'h0;
        end else begin
            downs_ff <= downs_ff + 4'h1;
        end
    end
    assign count_out = ups_ff - downs_ff;
endmodule

`default_nettype wire

// file: terminal_gate.sv
// active-low terminal count output: repeats the clock low phase at the end state
`timescale 1ns/1ps
`default_nettype none

module terminal_gate
    import counter_pkg::*;
(
    input wire logic at_terminal_in,
    count_clock_if.user clk_if,
    output logic flag_n_out
);

    // low only while at terminal and the clock is low
    assign flag_n_out = ~(at_terminal_in & ~clk_if.level);

endmodule

`default_nettype wire

// file: test_dual_clock_updown_counter4.sv
// self-checking bench for the dual clock up/down counter
`timescale 1ns/1ps
`default_nettype none

module test_dual_clock_updown_counter4;
    import counter_pkg::*;
    logic clk_in;
    logic rst_in;
    logic up;
    logic dn;
    logic load_n;
    logic mc;
    count_type val;
    count_type count;
    logic carry_n;
    logic borrow_n;
    logic [3:0] stage;
    int mismatches = 0;
    int check_count = 0;

    dual_clock_updown_counter4 u_dut (.clk_in(clk_in), .rst_in(rst_in),
        .up_count_clock_in(up), .down_count_clock_in(dn), .preset_load_n_in(load_n),
        .master_clear_in(mc), .preset_value_in(val), .count_value_out(count),
        .carry_out_n_out(carry_n), .borrow_out_n_out(borrow_n));
    next_stage_model u_next (.rst_in(rst_in), .up_in(carry_n), .down_in(borrow_n),
        .count_out(stage));

    initial begin
        clk_in = 1'h0;
        forever #20 clk_in = ~clk_in;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task check(input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ----------------------------------------
    // drive at falling edge, one rising edge passes
    // ----------------------------------------
    task put(input logic u, input logic d, input logic p, input logic m, input count_type v);
        up = u;
        dn = d;
        load_n = p;
        mc = m;
        val = v;
        @(negedge clk_in);
    endtask

    task test_up_wrap;
        put(1'h1, 1'h1, 1'h0, 1'h0, 4'hE);
        check(count, 4'hE);
        put(1'h0, 1'h1, 1'h1, 1'h0, 4'h0);
        check(carry_n, 1'h1);
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'hF);
        check(carry_n, 1'h1);
        put(1'h0, 1'h1, 1'h1, 1'h0, 4'h0);
        check(carry_n, 1'h0);
        check(count, 4'hF);
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'h0);
        check(stage, 4'h1);
    endtask

    // direction turned while the up clock is high
    task test_down_wrap;
        put(1'h1, 1'h0, 1'h1, 1'h0, 4'h0);
        check(borrow_n, 1'h0);
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'hF);
        check(borrow_n, 1'h1);
        check(stage, 4'h0);
    endtask

    task test_preset;
        put(1'h0, 1'h1, 1'h0, 1'h0, 4'hF);
        check(carry_n, 1'h0);
        put(1'h1, 1'h1, 1'h0, 1'h0, 4'h9);
        check(count, 4'h9);
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'h9);
    endtask

    task test_clear;
        put(1'h0, 1'h1, 1'h0, 1'h1, 4'hF);
        check(count, 4'h0);
        put(1'h0, 1'h0, 1'h1, 1'h1, 4'h0);
        check(borrow_n, 1'h0);
        put(1'h0, 1'h1, 1'h1, 1'h1, 4'h0);
        check(count, 4'h0);
        put(1'h0, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'h0);
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'h1);
    endtask

    // breaks the driving rules on purpose: a rise with the other clock low holds
    task test_blocked;
        put(1'h0, 1'h0, 1'h1, 1'h0, 4'h0);
        check(count, 4'h1);
        put(1'h1, 1'h0, 1'h1, 1'h0, 4'h0);
        check(count, 4'h1);
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'h0);
        put(1'h0, 1'h0, 1'h1, 1'h0, 4'h0);
        check(borrow_n, 1'h0);
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'h0);
    endtask

    initial begin
        rst_in = 1'h1;
        up = 1'h1;
        dn = 1'h1;
        load_n = 1'h1;
        mc = 1'h0;
        val = 4'h0;
        repeat (10) @(negedge clk_in);
        rst_in = 1'h0;
        put(1'h1, 1'h1, 1'h1, 1'h0, 4'h0);
        check(count, 4'h0);
        check(borrow_n, 1'h1);
        test_up_wrap();
        test_down_wrap();
        test_preset();
        test_clear();
        test_blocked();
        stop_test();
    end

    // whole run is some thirty cycles
    initial begin
        #80000;
        mismatches++;
        stop_test();
    end
endmodule

`default_nettype wire

// file: updown_counter_defs.svh
// constants of the dual clock up/down counter
`ifndef UPDOWN_COUNTER_DEFS_SVH
`define UPDOWN_COUNTER_DEFS_SVH

`define CNT_WIDTH 4
`define CNT_RESET_VALUE 4'h0
`define CNT_MAX_VALUE 4'hF
`define CNT_MIN_VALUE 4'h0
`define CNT_STEP 4'h1
`define CLK_IDLE_LEVEL 1'h1
`define FLAG_IDLE_LEVEL 1'h1

`endif
